/* File: hw/temp_conv_seq.sv */
`timescale 1ns/10ps

module temp_conv_seq
#(
   parameter int TICK_CYCLES = temp_seq_pkg::TICK_CYCLES,
   parameter int CONV_TICKS_9BIT = temp_seq_pkg::CONV_TICKS_9BIT
)
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire temp_seq_pkg::config_t CONFIG,
   input wire logic [temp_seq_pkg::SAMPLE_W-1:0] SAMPLE,
   input wire logic RESULT_READ,
   output temp_seq_pkg::read_rsp_t READ_RSP,
   output logic [temp_seq_pkg::RESULT_W-1:0] TEMPERATURE_RESULT,
   output logic RESULT_DONE,
   output logic CONVERTING,
   output logic STANDBY,
   output logic THERMOSTAT_CLEAR
);

   localparam logic [temp_seq_pkg::TICK_W-1:0] TICK_LAST =
      temp_seq_pkg::TICK_W'(TICK_CYCLES - 1);
   localparam logic [temp_seq_pkg::CONV_W-1:0] TERM_9BIT =
      temp_seq_pkg::CONV_W'(CONV_TICKS_9BIT);

   temp_seq_pkg::seq_state_t state;
   temp_seq_pkg::seq_state_t next_state;
   logic [temp_seq_pkg::TICK_W-1:0] tick_cnt;
   logic [temp_seq_pkg::CONV_W-1:0] conv_ticks;
   logic [temp_seq_pkg::CONV_W-1:0] terminal;
   logic [1:0] conv_res;
   logic [1:0] cfg_res;
   logic [temp_seq_pkg::RESULT_W-1:0] keep_mask;
   logic [temp_seq_pkg::RESULT_W-1:0] next_result;
   logic tick;
   logic conv_last;
   logic start_conv;
   logic lpr;

   // Resolution code from the two control bits, 00 meaning nine bits.
   assign cfg_res = {CONFIG.resolution_sel_hi, CONFIG.resolution_sel_lo};
   assign lpr = CONFIG.low_power_request;

   // Timebase pulse, one per microsecond at the default setting.
   assign tick = (state == temp_seq_pkg::ST_CONVERT) &&
      (tick_cnt == TICK_LAST);

   // Terminal count doubles with each extra bit of resolution.
   assign terminal = TERM_9BIT << conv_res;
   assign conv_last = tick && (conv_ticks == terminal - 1'b1);

   // A new conversion starts after the last one unless shutdown is asked for.
   assign start_conv = !lpr &&
      (conv_last || (state == temp_seq_pkg::ST_STANDBY));

   // Per-bit mask: keep bit i when it lies at or above the resolution's LSB.
   genvar gi;
   generate
      for (gi = 0; gi < temp_seq_pkg::RESULT_W; gi++)
      begin : g_mask
         assign keep_mask[gi] =
            (gi + int'(conv_res)) >= temp_seq_pkg::LSB_AT_9BIT;
      end
   endgenerate

   // Left-justified word with the sign in bit 15 and zeros below bit 4.
   assign next_result =
      {SAMPLE, temp_seq_pkg::FRAC_PAD'(0)} & keep_mask;

   // Next sequencer state.
   always_comb
   begin
      next_state = state;
      case (state)
         temp_seq_pkg::ST_CONVERT:
         begin
            if (conv_last && lpr)
            begin
               next_state = temp_seq_pkg::ST_STANDBY;
            end
         end
         temp_seq_pkg::ST_STANDBY:
         begin
            if (!lpr)
            begin
               next_state = temp_seq_pkg::ST_CONVERT;
            end
         end
         default:
         begin
            next_state = temp_seq_pkg::ST_CONVERT;
         end
      endcase
   end

   // State register; reset lands in a running conversion.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state <= temp_seq_pkg::ST_CONVERT;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Timebase prescaler; it stands still in standby to save power.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         tick_cnt <= '0;
      end
      else if (state != temp_seq_pkg::ST_CONVERT || tick)
      begin
         tick_cnt <= '0;
      end
      else
      begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   // Conversion timer in timebase ticks.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         conv_ticks <= '0;
      end
      else if (state != temp_seq_pkg::ST_CONVERT || conv_last)
      begin
         conv_ticks <= '0;
      end
      else if (tick)
      begin
         conv_ticks <= conv_ticks + 1'b1;
      end
   end

   // Resolution is held for a whole conversion so time and mask agree.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         conv_res <= temp_seq_pkg::RES_RESET;
      end
      else if (start_conv)
      begin
         conv_res <= cfg_res;
      end
   end

   // Result register, written only when a conversion completes.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         TEMPERATURE_RESULT <= temp_seq_pkg::RESULT_RESET;
         RESULT_DONE <= 1'b0;
      end
      else
      begin
         RESULT_DONE <= conv_last;
         if (conv_last)
         begin
            TEMPERATURE_RESULT <= next_result;
         end
      end
   end

   // Status flags and the thermostat clear pulse on entering shutdown.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         CONVERTING <= 1'b1;
         STANDBY <= 1'b0;
         THERMOSTAT_CLEAR <= 1'b0;
      end
      else
      begin
         CONVERTING <= (next_state == temp_seq_pkg::ST_CONVERT);
         STANDBY <= (next_state == temp_seq_pkg::ST_STANDBY);
         THERMOSTAT_CLEAR <=
            conv_last && lpr && CONFIG.thermostat_mode_sel;
      end
   end

   // Host read snapshot; it only samples and never touches the sequencer.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         READ_RSP <= '0;
      end
      else
      begin
         READ_RSP.ack <= RESULT_READ;
         if (RESULT_READ)
         begin
            READ_RSP.data <= TEMPERATURE_RESULT;
         end
      end
   end

   // Checks on the sequencer and the result word.
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   property p_powerup;
      $rose(ARST_N) |-> state == temp_seq_pkg::ST_CONVERT;
   endproperty
   a_powerup: assert property (p_powerup)
      else $error("not converting after reset");

   property p_low_zero;
      TEMPERATURE_RESULT[3:0] == 4'h0;
   endproperty
   a_low_zero: assert property (p_low_zero)
      else $error("low result bits not zero");

   property p_unused_zero;
      RESULT_DONE |-> (TEMPERATURE_RESULT &
         ~(16'hFFFF << (3'h7 - $past(conv_res)))) == '0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused result bits not zero");

   property p_store;
      conv_last |=> RESULT_DONE && TEMPERATURE_RESULT ==
         ({$past(SAMPLE), 4'h0} & (16'hFFFF << (3'h7 - $past(conv_res))));
   endproperty
   a_store: assert property (p_store)
      else $error("result not stored at conversion end");

   property p_sign;
      RESULT_DONE |-> TEMPERATURE_RESULT[15] == $past(SAMPLE[11]);
   endproperty
   a_sign: assert property (p_sign)
      else $error("sign bit wrong");

   property p_bound;
      conv_ticks < terminal && tick_cnt <= TICK_LAST;
   endproperty
   a_bound: assert property (p_bound)
      else $error("conversion overran its maximum time");

   property p_terminal;
      conv_last |-> conv_ticks == (TERM_9BIT << conv_res) - 1'b1;
   endproperty
   a_terminal: assert property (p_terminal)
      else $error("terminal count not scaled by resolution");

   property p_no_disturb;
      RESULT_READ && state == temp_seq_pkg::ST_CONVERT && !conv_last
         |=> state == temp_seq_pkg::ST_CONVERT && $stable(conv_res)
         && $stable(TEMPERATURE_RESULT);
   endproperty
   a_no_disturb: assert property (p_no_disturb)
      else $error("read disturbed the conversion");

   property p_shutdown;
      conv_last && lpr |=> STANDBY && RESULT_DONE ##1 conv_ticks == '0;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("shutdown not entered after conversion");

   property p_clear;
      conv_last && lpr |=>
         THERMOSTAT_CLEAR == $past(CONFIG.thermostat_mode_sel);
   endproperty
   a_clear: assert property (p_clear)
      else $error("thermostat clear wrong on shutdown");

   property p_read;
      RESULT_READ |=> READ_RSP.ack &&
         READ_RSP.data == $past(TEMPERATURE_RESULT);
   endproperty
   a_read: assert property (p_read)
      else $error("read did not return latest result");

   property p_wake;
      state == temp_seq_pkg::ST_STANDBY && !lpr |=> CONVERTING
         && conv_res == $past(cfg_res);
   endproperty
   a_wake: assert property (p_wake)
      else $error("conversions did not resume");

   c_shutdown: cover property (conv_last && lpr);
   c_wake: cover property (state == temp_seq_pkg::ST_STANDBY && !lpr);
   c_read_standby: cover property (STANDBY && RESULT_READ);
   c_twelve_bit: cover property (conv_last && conv_res == 2'h3);

endmodule

/* File: common/temp_seq_pkg.sv */
package temp_seq_pkg;

   // Core clock and the internal timebase that paces conversions.
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = TICK_NS * (CLK_HZ / 1_000_000) / 1000;

   // Longest conversion time at the lowest resolution, in ms and in ticks.
   localparam int CONV_MS_9BIT = 150;
   localparam int CONV_TICKS_9BIT = CONV_MS_9BIT * (1_000_000 / TICK_NS);

   // Widths of the counters, the raw sample and the result word.
   localparam int TICK_W = 16;
   localparam int CONV_W = 24;
   localparam int SAMPLE_W = 12;
   localparam int RESULT_W = 16;
   localparam int FRAC_PAD = 4;

   // Lowest kept result bit at the nine-bit setting.
   localparam int LSB_AT_9BIT = 7;

   // Values after reset.
   localparam logic [1:0] RES_RESET = 2'h0;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Sequencer states.
   typedef enum logic [1:0]
   {
      ST_CONVERT = 2'b01,
      ST_STANDBY = 2'b10
   } seq_state_t;

   // Control bits driven by the host side of the device.
   typedef struct packed
   {
      logic low_power_request;
      logic thermostat_mode_sel;
      logic resolution_sel_hi;
      logic resolution_sel_lo;
   } config_t;

   // Snapshot returned to a host read of the result register.
   typedef struct packed
   {
      logic ack;
      logic [15:0] data;
   } read_rsp_t;

endpackage

/* File: bench/host_read_model.sv */
`timescale 1ns/10ps

// Host reader that issues a burst of back-to-back result reads.
module host_read_model
(
   input wire logic clk,
   input wire logic stb,
   input wire logic [3:0] len,
   output logic rd
);
   logic [3:0] left = 4'h0;
   logic issuing = 1'b0;

   // A strobe loads the burst length; one read per cycle then follows.
   // Updates land just after the rising edge, clear of the bench's drive.
   always @(posedge clk)
   begin
      issuing <= (left != 4'h0);
      left <= stb ? len : ((left != 4'h0) ? left - 4'h1 : 4'h0);
   end

   // The read strobe is the registered burst flag.
   assign rd = issuing;
endmodule

/* File: bench/tb_temp_conv_seq.sv */
`timescale 1ns/10ps

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
$display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module tb_temp_conv_seq;
   localparam int TICKS = 2;
   localparam int CONVS = 5;
   logic CLK = 1'b0;
   logic ARST_N = 1'b0;
   temp_seq_pkg::config_t CONFIG = '0;
   logic [11:0] SAMPLE = 12'h000;
   logic RESULT_READ;
   temp_seq_pkg::read_rsp_t READ_RSP;
   logic [15:0] TEMPERATURE_RESULT;
   logic RESULT_DONE;
   logic CONVERTING;
   logic STANDBY;
   logic THERMOSTAT_CLEAR;
   logic rd_stb = 1'b0;
   logic [3:0] rd_len = 4'h0;
   int error_cnt = 0;
   int comparisons = 0;
   int done_cnt = 0;
   int cycles = 0;
   int n;
   logic [15:0] exp_word[$];
   logic [15:0] exp_read[$];
   logic [15:0] last_word;
   logic [1:0] pending;

   temp_conv_seq #(.TICK_CYCLES(TICKS), .CONV_TICKS_9BIT(CONVS)) DUT
   (
      .CLK(CLK),
      .ARST_N(ARST_N),
      .CONFIG(CONFIG),
      .SAMPLE(SAMPLE),
      .RESULT_READ(RESULT_READ),
      .READ_RSP(READ_RSP),
      .TEMPERATURE_RESULT(TEMPERATURE_RESULT),
      .RESULT_DONE(RESULT_DONE),
      .CONVERTING(CONVERTING),
      .STANDBY(STANDBY),
      .THERMOSTAT_CLEAR(THERMOSTAT_CLEAR)
   );

   host_read_model HOST
   (
      .clk(CLK),
      .stb(rd_stb),
      .len(rd_len),
      .rd(RESULT_READ)
   );

   // The clock toggles every half period of 4 ns.
   initial
   begin
      forever #4 CLK = ~CLK;
   end

   // A hang is cut short after a fixed number of cycles.
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   // Stored results and read answers are matched against the notes.
   always @(negedge CLK)
   begin
      if (RESULT_DONE === 1'b1)
      begin
         done_cnt++;
         `CHK(TEMPERATURE_RESULT, exp_word.pop_front())
      end
      if (READ_RSP.ack === 1'b1)
         `CHK(READ_RSP.data, exp_read.pop_front())
   end

   // The expected word keeps only the bits that the resolution allows.
   function automatic logic [15:0] expect_word(logic [11:0] s, logic [1:0] r);
      return {s, 4'h0} & (16'hFFFF << (7 - int'(r)));
   endfunction

   // Waits for the next stored result, counting cycles.
   task automatic wait_done(output int c);
      c = 0;
      do
      begin
         @(negedge CLK);
         c++;
      end
      while (RESULT_DONE !== 1'b1 && c < 400);
   endtask

   // Runs one conversion with a read burst issued meanwhile.
   task automatic convert(logic [1:0] r, logic lp, logic tm, logic fresh);
      logic [1:0] run;
      logic [15:0] w;
      int c;
      run = fresh ? r : pending;
      pending = r;
      CONFIG = '{lp, tm, r[1], r[0]};
      SAMPLE = 12'($urandom);
      w = expect_word(SAMPLE, run);
      exp_word.push_back(w);
      rd_len = 4'(1 + $urandom_range(3));
      rd_stb = 1'b1;
      repeat (rd_len) exp_read.push_back(last_word);
      @(negedge CLK);
      rd_stb = 1'b0;
      if (fresh)
         `CHK(CONVERTING, 1'b1)
      wait_done(c);
      `CHK(c + 1, TICKS * (CONVS << run) + int'(fresh))
      last_word = w;
   endtask

   // Prints the verdict and ends the run.
   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence: power-up, all resolutions, shutdown and resume.
   initial
   begin
      void'($urandom(32'h95BF));
      CONFIG = '{1'b0, 1'b0, 1'b1, 1'b1};
      SAMPLE = 12'($urandom);
      repeat (6) @(negedge CLK);
      `CHK(TEMPERATURE_RESULT, 16'h0000)
      last_word = expect_word(SAMPLE, 2'h0);
      exp_word.push_back(last_word);
      ARST_N = 1'b1;
      wait_done(n);
      `CHK(n, TICKS * CONVS)
      `CHK(CONVERTING, 1'b1)
      pending = 2'h3;
      for (int i = 0; i < 12; i++)
         convert(2'(i), 1'b0, 1'b0, 1'b0);
      convert(2'h1, 1'b1, 1'b1, 1'b0);
      `CHK(STANDBY, 1'b1)
      `CHK(THERMOSTAT_CLEAR, 1'b1)
      @(negedge CLK);
      n = done_cnt;
      rd_len = 4'h3;
      rd_stb = 1'b1;
      repeat (3) exp_read.push_back(last_word);
      @(negedge CLK);
      rd_stb = 1'b0;
      repeat (30) @(negedge CLK);
      `CHK(done_cnt, n)
      `CHK(CONVERTING, 1'b0)
      convert(2'h2, 1'b0, 1'b1, 1'b1);
      convert(2'h0, 1'b1, 1'b0, 1'b0);
      `CHK(STANDBY, 1'b1)
      `CHK(THERMOSTAT_CLEAR, 1'b0)
      repeat (4) @(negedge CLK);
      `CHK(exp_word.size(), 0)
      `CHK(exp_read.size(), 0)
      report_and_stop();
   end
endmodule
